// ---- design/ict_defs.svh ----
// Holds the offsets, bit positions, reset values and status codes of the
// two-wire serial control and time-out block.
// Assumes it is included by bare name wherever these names are needed.
`ifndef ICT_DEFS_SVH
`define ICT_DEFS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ICT_OFS_TOC 8'hBF
`define ICT_OFS_CON 8'hC0
`define ICT_OFS_STAT 8'hBD

// ****************************************************************
// Reset values
// ****************************************************************
`define ICT_TOC_RST 8'h09
`define ICT_CON_RST 8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define ICT_TOC_EN 2
`define ICT_TOC_DIV 1
`define ICT_TOC_FLAG 0
`define ICT_CON_EN 6
`define ICT_CON_STA 5
`define ICT_CON_STO 4
`define ICT_CON_SI 3
`define ICT_CON_AA 2
`define ICT_CON_PX 0

// ****************************************************************
// Status codes and counts
// ****************************************************************
`define ICT_ST_BUSERR 5'h00
`define ICT_ST_START 5'h01
`define ICT_ST_RSTART 5'h02
`define ICT_ST_TX_ACK 5'h05
`define ICT_ST_TX_NACK 5'h06
`define ICT_ST_ARB_LOST 5'h07
`define ICT_ST_RX_ACK 5'h0A
`define ICT_ST_RX_NACK 5'h0B
`define ICT_ST_IDLE 5'h1F
`define ICT_TO_W 14
`define ICT_PRE_LAST 2'h3
`define ICT_ACK_BIT 4'h8
`define ICT_Q_HIGH 2'h1
`define ICT_Q_SAMPLE 2'h2
`define ICT_Q_LAST 2'h3

`endif

// ---- design/ict_pkg.sv ----
// Holds the types of the two-wire serial control and time-out block.
// Assumes nothing beyond a SystemVerilog compiler.
package ict_pkg;

   typedef enum logic [4:0] {
      ICT_IDLE = 5'h01,
      ICT_START = 5'h02,
      ICT_SHIFT = 5'h04,
      ICT_HOLD = 5'h08,
      ICT_STOP = 5'h10
   } ict_state_t;

   typedef struct packed {
      logic scl;
      logic sda;
   } ict_lines_t;

endpackage

// ---- design/ict_ctrl.sv ----
// Holds the control and time-out logic of an on-chip two-wire serial
// controller: registers, condition generator, byte engine, time-out.
// Assumes a byte-wide register port on CLK and open-drain pads outside.
//
// Behaviour
// RULE1: Time-out counter runs only when enabled.
// RULE2: Time-out clock is system clock over 1 or 4.
// RULE3: Counter overflow sets sticky time-out flag.
// RULE4: Bus interface operates only while enabled.
// RULE5: Software sets pin latches high before enabling.
// RULE6: Start request waits for free bus.
// RULE7: Start request after a byte gives repeated start.
// RULE8: Start request cleared only by software.
// RULE9: Stop request sends stop, cleared on detection.
// RULE10: Stop request in bus error just recovers.
// RULE11: Both requests as master: stop then start.
// RULE12: Slave software avoids both requests together.
// RULE13: Meaningful state entry sets the event flag.
// RULE14: Only software clears the event flag.
// RULE15: Event flag set holds clock line low. Code releases it when bus error or lost arbitration sets the flag.
// RULE16: After flag clear, continue per control bits.
// RULE17: Ack assert bit chooses ACK or NACK.
// RULE18: Pin select switches pin pair at once.
// RULE19: Status code in upper five bits.
// RULE20: Counter clears when disabled or flag cleared.
// RULE21: Software writes flag; overflow wins.
`timescale 1ns/10ps

module ict_ctrl
   import ict_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   input wire logic [7:0] BIT_RATE,
   input wire logic [7:0] TX_DATA,
   input wire logic XFER_RECEIVE,
   output logic [7:0] RX_DATA,
   input wire logic SCL0_I,
   output logic SCL0_O,
   output logic SCL0_OE_N,
   input wire logic SDA0_I,
   output logic SDA0_O,
   output logic SDA0_OE_N,
   input wire logic SCL1_I,
   output logic SCL1_O,
   output logic SCL1_OE_N,
   input wire logic SDA1_I,
   output logic SDA1_O,
   output logic SDA1_OE_N
);

`include "ict_defs.svh"

   // ****************************************************************
   // Register decode
   // ****************************************************************
   wire logic wr_toc = WR & (ADDR == `ICT_OFS_TOC);
   wire logic wr_con = WR & (ADDR == `ICT_OFS_CON);
   logic [7:0] toc_r;
   logic [7:0] con_r;
   logic [4:0] code_r;
   logic [7:0] rdata_r;
   wire logic to_en = toc_r[`ICT_TOC_EN];
   wire logic bus_en = con_r[`ICT_CON_EN];
   wire logic begin_condition_request = con_r[`ICT_CON_STA]; // RULE8
   wire logic halt_condition_request = con_r[`ICT_CON_STO];
   wire logic si = con_r[`ICT_CON_SI];
   wire logic aa = con_r[`ICT_CON_AA];
   wire logic px = con_r[`ICT_CON_PX];
   wire logic [7:0] stat_rd = {code_r, 3'h0}; // RULE19
   wire logic [7:0] toc_rd = {5'h00, toc_r[2:0]};
   wire logic [7:0] con_rd = {1'b0, con_r[6:2], 1'b0, con_r[0]};
   wire logic [7:0] rd_sel = (ADDR == `ICT_OFS_TOC) ? toc_rd :
      (ADDR == `ICT_OFS_CON) ? con_rd :
      (ADDR == `ICT_OFS_STAT) ? stat_rd : 8'h00;
   wire logic si_sw_clr = wr_con & ~WDATA[`ICT_CON_SI] & si;

   // ****************************************************************
   // Pin synchronisers and pair selection
   // ****************************************************************
   ict_lines_t p0_s1_r, p0_s2_r, p1_s1_r, p1_s2_r;
   ict_lines_t prev_r;
   wire ict_lines_t lines = px ? p1_s2_r : p0_s2_r; // RULE18
   wire logic start_seen = prev_r.scl & lines.scl & prev_r.sda & ~lines.sda;
   wire logic stop_seen = prev_r.scl & lines.scl & ~prev_r.sda & lines.sda;

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         p0_s1_r <= 2'h3;
         p0_s2_r <= 2'h3;
         p1_s1_r <= 2'h3;
         p1_s2_r <= 2'h3;
         prev_r <= 2'h3;
      end else begin
         p0_s1_r <= {SCL0_I, SDA0_I};
         p0_s2_r <= p0_s1_r;
         p1_s1_r <= {SCL1_I, SDA1_I};
         p1_s2_r <= p1_s1_r;
         prev_r <= lines;
      end
   end

   // ****************************************************************
   // Pin drive
   // ****************************************************************
   logic scl_low_r;
   logic sda_low_r;
   wire logic scl_low = bus_en & scl_low_r;
   wire logic sda_low = bus_en & sda_low_r;
   assign SCL0_O = 1'b0;
   assign SDA0_O = 1'b0;
   assign SCL1_O = 1'b0;
   assign SDA1_O = 1'b0;
   assign SCL0_OE_N = ~(scl_low & ~px); // RULE18
   assign SDA0_OE_N = ~(sda_low & ~px);
   assign SCL1_OE_N = ~(scl_low & px);
   assign SDA1_OE_N = ~(sda_low & px);

   // ****************************************************************
   // Quarter bit timing
   // ****************************************************************
   logic [7:0] qdiv_r;
   logic [1:0] q_r;
   wire logic tick = (qdiv_r == 8'h00);
   // The clock is released in q1, so q2 waits for it to read high.
   wire logic scl_wait = (q_r == `ICT_Q_SAMPLE) & ~lines.scl;
   wire logic adv = tick & ~scl_wait;
   wire logic q_last = adv & (q_r == `ICT_Q_LAST);

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         qdiv_r <= 8'h00;
      end else begin
         qdiv_r <= tick ? BIT_RATE : qdiv_r - 8'h01;
      end
   end

   // ****************************************************************
   // Condition generator and byte engine
   // ****************************************************************
   ict_state_t state_r, state_nxt;
   logic master_r, moved_r, bus_busy_r, rx_r, ack_in_r;
   logic [3:0] bit_r;
   logic [7:0] sh_r;
   logic si_set;
   logic [4:0] code_nxt;
   logic sto_hw_clr;
   wire logic bit_ack = (bit_r == `ICT_ACK_BIT);
   wire logic lost = (state_r == ICT_SHIFT) & adv & ~bit_ack & ~rx_r &
      (q_r == `ICT_Q_SAMPLE) & ~sda_low_r & ~lines.sda;
   wire logic bus_err = (state_r == ICT_SHIFT) & (start_seen | stop_seen);
   wire logic byte_done = (state_r == ICT_SHIFT) & q_last & bit_ack;
   wire logic go_start = bus_en & begin_condition_request & ~si & ~bus_busy_r; // RULE6

   always_comb begin
      state_nxt = state_r;
      si_set = 1'b0;
      code_nxt = code_r;
      sto_hw_clr = stop_seen; // RULE9
      unique case (state_r)
         ICT_IDLE: begin
            if (halt_condition_request & (code_r == `ICT_ST_BUSERR)) begin
               sto_hw_clr = 1'b1; // RULE10
               code_nxt = `ICT_ST_IDLE;
            end else if (go_start) begin
               state_nxt = ICT_START;
            end
         end
         ICT_START: begin
            if (q_last) begin
               state_nxt = ICT_HOLD;
               si_set = 1'b1; // RULE13
               code_nxt = moved_r ? `ICT_ST_RSTART : `ICT_ST_START; // RULE7
            end
         end
         ICT_SHIFT: begin
            if (bus_err) begin
               state_nxt = ICT_IDLE;
               si_set = 1'b1;
               code_nxt = `ICT_ST_BUSERR;
            end else if (lost) begin
               state_nxt = ICT_IDLE;
               si_set = 1'b1;
               code_nxt = `ICT_ST_ARB_LOST;
            end else if (byte_done) begin
               state_nxt = ICT_HOLD;
               si_set = 1'b1; // RULE13
               if (rx_r) begin
                  code_nxt = aa ? `ICT_ST_RX_ACK : `ICT_ST_RX_NACK;
               end else begin
                  code_nxt = ack_in_r ? `ICT_ST_TX_ACK : `ICT_ST_TX_NACK;
               end
            end
         end
         ICT_HOLD: begin
            if (~si) begin // RULE16
               if (halt_condition_request) begin
                  state_nxt = ICT_STOP; // RULE11
               end else if (begin_condition_request) begin
                  state_nxt = ICT_START; // RULE7
               end else begin
                  state_nxt = ICT_SHIFT;
               end
            end
         end
         ICT_STOP: begin
            if (q_last) begin
               state_nxt = ICT_IDLE;
               code_nxt = `ICT_ST_IDLE;
            end
         end
      endcase
      if (~bus_en) begin // RULE4
         state_nxt = ICT_IDLE;
         si_set = 1'b0;
         code_nxt = `ICT_ST_IDLE;
      end
   end

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         state_r <= ICT_IDLE;
         code_r <= `ICT_ST_IDLE;
         bus_busy_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         code_r <= code_nxt;
         bus_busy_r <= bus_en & (start_seen | (bus_busy_r & ~stop_seen));
      end
   end

   // Bit sequencing: q0 sets data, q1 releases clock, q2 samples, q3 lowers.
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         q_r <= 2'h0;
         scl_low_r <= 1'b0;
         sda_low_r <= 1'b0;
         master_r <= 1'b0;
         moved_r <= 1'b0;
         rx_r <= 1'b0;
         ack_in_r <= 1'b0;
         bit_r <= 4'h0;
         sh_r <= 8'h00;
         RX_DATA <= 8'h00;
      end else if (state_nxt == ICT_IDLE) begin
         q_r <= 2'h0;
         scl_low_r <= 1'b0;
         sda_low_r <= 1'b0;
         master_r <= 1'b0;
         moved_r <= 1'b0;
      end else if (state_r == ICT_HOLD || state_r == ICT_IDLE) begin
         q_r <= 2'h0;
         scl_low_r <= master_r; // RULE15
         bit_r <= 4'h0;
         sh_r <= TX_DATA;
         rx_r <= XFER_RECEIVE;
      end else if (adv) begin
         q_r <= q_r + 2'h1;
         unique case (q_r)
            2'h0: begin
               if (state_r == ICT_START) begin
                  sda_low_r <= 1'b0;
               end else if (state_r == ICT_STOP) begin
                  sda_low_r <= 1'b1;
               end else if (bit_ack) begin
                  sda_low_r <= rx_r & aa; // RULE17
               end else begin
                  sda_low_r <= ~rx_r & ~sh_r[7];
               end
            end
            2'h1: scl_low_r <= 1'b0;
            2'h2: begin
               if (state_r != ICT_SHIFT) begin
                  sda_low_r <= (state_r == ICT_START);
               end else if (bit_ack) begin
                  ack_in_r <= ~lines.sda;
               end else begin
                  sh_r <= {sh_r[6:0], lines.sda};
               end
            end
            2'h3: begin
               scl_low_r <= (state_r != ICT_STOP);
               master_r <= 1'b1;
               if (state_r == ICT_SHIFT) begin
                  bit_r <= bit_r + 4'h1;
               end
               if (byte_done) begin
                  moved_r <= 1'b1;
                  if (rx_r) begin
                     RX_DATA <= sh_r;
                  end
               end
            end
         endcase
      end
   end

   // ****************************************************************
   // Time-out counter
   // ****************************************************************
   logic [1:0] pre_r;
   logic [`ICT_TO_W-1:0] to_cnt_r;
   wire logic to_tick = toc_r[`ICT_TOC_DIV] ? (pre_r == `ICT_PRE_LAST) :
      1'b1; // RULE2
   wire logic to_clr = ~to_en | si_sw_clr; // RULE20
   wire logic to_ovf = to_en & to_tick & (&to_cnt_r); // RULE3

   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         pre_r <= 2'h0;
         to_cnt_r <= '0;
      end else if (to_clr) begin
         pre_r <= 2'h0;
         to_cnt_r <= '0;
      end else begin
         pre_r <= pre_r + 2'h1; // RULE1
         to_cnt_r <= to_tick ? to_cnt_r + 1'b1 : to_cnt_r;
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   always_ff @(posedge CLK or posedge RESET) begin
      if (RESET) begin
         toc_r <= `ICT_TOC_RST;
         con_r <= `ICT_CON_RST;
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= RD ? rd_sel : 8'h00;
         if (wr_toc) begin
            toc_r[2:1] <= WDATA[2:1];
         end
         toc_r[`ICT_TOC_FLAG] <= to_ovf |
            (wr_toc ? WDATA[`ICT_TOC_FLAG] : toc_r[`ICT_TOC_FLAG]); // RULE21
         if (wr_con) begin
            con_r <= {1'b0, WDATA[6:5], WDATA[4] | (halt_condition_request & ~sto_hw_clr),
               WDATA[3] | si_set, WDATA[2], 1'b0, WDATA[0]}; // RULE14
         end else begin
            con_r[`ICT_CON_STO] <= halt_condition_request & ~sto_hw_clr; // RULE9
            con_r[`ICT_CON_SI] <= si | si_set; // RULE13
         end
      end
   end

   assign RDATA = rdata_r;

endmodule

// ---- sim/ict_ctrl_checker.sv ----
// Concurrent checks of the serial control block at its top ports.
// Assumes one clock domain; the bind stands at the foot of this file.
`timescale 1ns/10ps
`include "ict_defs.svh"
module ict_ctrl_checker
   import ict_pkg::*;
(
   input wire logic CLK,
   input wire logic RESET,
   input wire logic [7:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   input wire logic SCL0_O,
   input wire logic SDA0_O,
   input wire logic SCL0_OE_N,
   input wire logic SDA0_OE_N,
   input wire logic SCL1_OE_N,
   input wire logic SDA1_OE_N
);
   // ********
   // Checks
   // ********
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RESET);
   wire rd_con = RD && ADDR == `ICT_OFS_CON;
   wire rd_toc = RD && ADDR == `ICT_OFS_TOC;
   wire rd_stat = RD && ADDR == `ICT_OFS_STAT;
   wire wr_toc = WR && ADDR == `ICT_OFS_TOC;
   wire wr_con = WR && ADDR == `ICT_OFS_CON;
   wire all_free = SCL0_OE_N && SDA0_OE_N && SCL1_OE_N && SDA1_OE_N;
   property p_pair;
      !(SCL0_OE_N && SDA0_OE_N) |-> SCL1_OE_N && SDA1_OE_N;
   endproperty
   a_pair: assert property (p_pair)
      else $error("both pin pairs active");
   property p_odrain;
      !(SCL0_O || SDA0_O);
   endproperty
   a_odrain: assert property (p_odrain)
      else $error("pin driven high");
   property p_dis;
      wr_con && !WDATA[6] |=> all_free;
   endproperty
   a_dis: assert property (p_dis)
      else $error("pins not released when disabled");
   property p_idle_rd;
      !$past(RD) |-> RDATA == 8'h00;
   endproperty
   a_idle_rd: assert property (p_idle_rd)
      else $error("read data outside read slot");
   property p_stat_lo;
      rd_stat |=> RDATA[2:0] == 3'h0;
   endproperty
   a_stat_lo: assert property (p_stat_lo)
      else $error("status low bits not zero");
   property p_flag_wr;
      wr_toc && WDATA[2:0] == 3'h0 ##1 rd_toc |=> RDATA == 8'h00;
   endproperty
   a_flag_wr: assert property (p_flag_wr)
      else $error("time-out flag not cleared by write");
   property p_stretch;
      $past(rd_con) && RDATA[6] && RDATA[3] && !RDATA[0] |-> !SCL0_OE_N;
   endproperty
   a_stretch: assert property (p_stretch)
      else $error("clock not held during event");
   property p_start;
      $fell(SDA0_OE_N) && SCL0_OE_N |-> SCL0_OE_N [*2];
   endproperty
   a_start: assert property (p_start)
      else $error("clock low too soon after start");
endmodule
bind ict_ctrl ict_ctrl_checker chk (.CLK(CLK), .RESET(RESET),
   .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
   .SCL0_O(SCL0_O), .SDA0_O(SDA0_O), .SCL0_OE_N(SCL0_OE_N),
   .SDA0_OE_N(SDA0_OE_N), .SCL1_OE_N(SCL1_OE_N), .SDA1_OE_N(SDA1_OE_N));

// ---- sim/ict_bus_model.sv ----
// Far side of the two-wire bus: pull-ups and one slave on pin pair 0.
// Assumes open-drain enables from the block, active low.
`timescale 1ns/10ps
module ict_bus_model
(
   input wire logic scl0_oe_n,
   input wire logic sda0_oe_n,
   input wire logic scl1_oe_n,
   input wire logic sda1_oe_n,
   input wire logic ack_en,
   input wire logic send_en,
   input wire logic [7:0] send_byte,
   output logic scl0,
   output logic sda0,
   output logic scl1,
   output logic sda1
);
   // ********
   // Slave
   // ********
   logic [3:0] cnt_r = 4'h9;
   logic pull;
   assign pull = (cnt_r == 4'h8) ? ack_en :
      (cnt_r < 4'h8 && send_en && !send_byte[3'h7 - cnt_r[2:0]]);
   // Released lines float to the pull-up level.
   // The clock settles just after data, so a pair swap reads as a start.
   assign #1 scl0 = scl0_oe_n;
   assign sda0 = sda0_oe_n && !pull;
   assign scl1 = scl1_oe_n;
   assign sda1 = sda1_oe_n;
   always @(negedge sda0) if (scl0) cnt_r <= 4'hF;
   always @(negedge scl0) cnt_r <= (cnt_r == 4'h8) ? 4'h0 : cnt_r + 4'h1;
endmodule

// ---- sim/tb_ict_ctrl.sv ----
// Self-checking bench of the serial control and time-out block.
// Assumes the bus model on the pins and the bound checker.
`timescale 1ns/10ps
`include "ict_defs.svh"
module tb_ict_ctrl
   import ict_pkg::*;
;
   logic CLK = 1'b0, RESET = 1'b1, WR = 1'b0, RD = 1'b0, rx = 1'b0;
   logic [7:0] ADDR = 8'h00, WDATA = 8'h00, RDATA, RX_DATA, d;
   logic ack_en = 1'b1, send_en = 1'b0;
   logic scl0_oe_n, sda0_oe_n, scl1_oe_n, sda1_oe_n;
   logic scl0, sda0, scl1, sda1;
   logic [8:0] sh;
   int num_errors = 0, comparisons = 0;
   logic [23:0] rows [7] = '{24'hBF0202, 24'hBF0101, 24'hBF0000,
      24'hC02525, 24'hC00000, 24'hBDFFF8, 24'h55FF00};
   wire [8:0] pins = {5'h00, scl0_oe_n, sda0_oe_n, scl1_oe_n, sda1_oe_n};
   always #25 CLK = ~CLK;
   ict_ctrl uut (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA),
      .WR(WR), .RD(RD), .RDATA(RDATA), .BIT_RATE(8'h02),
      .TX_DATA(8'hA6), .XFER_RECEIVE(rx), .RX_DATA(RX_DATA),
      .SCL0_I(scl0), .SCL0_O(), .SCL0_OE_N(scl0_oe_n),
      .SDA0_I(sda0), .SDA0_O(), .SDA0_OE_N(sda0_oe_n),
      .SCL1_I(scl1), .SCL1_O(), .SCL1_OE_N(scl1_oe_n),
      .SDA1_I(sda1), .SDA1_O(), .SDA1_OE_N(sda1_oe_n));
   ict_bus_model far (.scl0_oe_n(scl0_oe_n), .sda0_oe_n(sda0_oe_n),
      .scl1_oe_n(scl1_oe_n), .sda1_oe_n(sda1_oe_n), .ack_en(ack_en),
      .send_en(send_en), .send_byte(8'h3C), .scl0(scl0), .sda0(sda0),
      .scl1(scl1), .sda1(sda1));
   // Last nine bits seen on the wire, cleared at each start condition.
   always @(negedge sda0) if (scl0) sh <= 9'h000;
   always @(posedge scl0) sh <= {sh[7:0], sda0};
   // ********
   // Tasks
   // ********
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      ADDR <= a;
      WDATA <= v;
      WR <= 1'b1;
      @(posedge CLK);
      WR <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a);
      ADDR <= a;
      RD <= 1'b1;
      @(posedge CLK);
      RD <= 1'b0;
      #1 d = RDATA;
      @(posedge CLK);
   endtask
   task automatic chk(input string n, input logic [8:0] e,
      input logic [8:0] g);
      comparisons++;
      if (g !== e) begin
         num_errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic rchk(input string n, input logic [7:0] a,
      input logic [7:0] e);
      rd(a);
      chk(n, {1'b0, e}, {1'b0, d});
   endtask
   // Polls the control register until bit b reads v, with a bound.
   task automatic wait_bit(input int b, input logic v);
      d = {8{~v}};
      for (int i = 0; i < 500 && d[b] !== v; i++) rd(`ICT_OFS_CON);
   endtask
   task automatic summarize;
      $display("comparisons %0d errors %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // ********
   // Tests
   // ********
   initial begin
      repeat (12) @(posedge CLK);
      RESET <= 1'b0;
      @(posedge CLK);
      rchk("toc reset", `ICT_OFS_TOC, `ICT_TOC_RST & 8'h07);
      rchk("con reset", `ICT_OFS_CON, `ICT_CON_RST);
      rchk("stat reset", `ICT_OFS_STAT, 8'hF8);
      $display("reset test done");
      foreach (rows[i]) begin
         wr(rows[i][23:16], rows[i][15:8]);
         rchk("reg row", rows[i][23:16], rows[i][7:0]);
      end
      chk("pins while off", 9'h00F, pins);
      $display("register test done");
      wr(`ICT_OFS_TOC, 8'h04);
      repeat (16300) @(posedge CLK);
      rchk("no overflow yet", `ICT_OFS_TOC, 8'h04);
      repeat (100) @(posedge CLK);
      rchk("overflow", `ICT_OFS_TOC, 8'h05);
      repeat (300) @(posedge CLK);
      rchk("flag sticky", `ICT_OFS_TOC, 8'h05);
      wr(`ICT_OFS_TOC, 8'h06);
      repeat (16400) @(posedge CLK);
      rchk("divide by four", `ICT_OFS_TOC, 8'h06);
      wr(`ICT_OFS_TOC, 8'h00);
      @(posedge CLK);
      wr(`ICT_OFS_TOC, 8'h04);
      repeat (15000) @(posedge CLK);
      rchk("count cleared", `ICT_OFS_TOC, 8'h04);
      wr(`ICT_OFS_TOC, 8'h00);
      @(posedge CLK);
      $display("time-out test done");
      wr(`ICT_OFS_CON, 8'h64);
      wait_bit(3, 1'b1);
      chk("begin kept", 9'h06C, {1'b0, d});
      rchk("start code", `ICT_OFS_STAT, 8'h08);
      repeat (20) @(posedge CLK);
      chk("stretch", 9'h000, {8'h00, scl0_oe_n});
      wr(`ICT_OFS_CON, 8'h4D);
      @(negedge CLK);
      chk("pair swap", 9'h002, {7'h00, scl0_oe_n, scl1_oe_n});
      @(posedge CLK);
      wr(`ICT_OFS_CON, 8'h44);
      wait_bit(3, 1'b1);
      rchk("tx code", `ICT_OFS_STAT, 8'h28);
      chk("tx wire", 9'h14C, sh);
      wr(`ICT_OFS_CON, 8'h64);
      wait_bit(3, 1'b1);
      rchk("rstart code", `ICT_OFS_STAT, 8'h10);
      rx <= 1'b1;
      send_en <= 1'b1;
      ack_en <= 1'b0;
      wr(`ICT_OFS_CON, 8'h44);
      wait_bit(3, 1'b1);
      rchk("rx ack code", `ICT_OFS_STAT, 8'h50);
      chk("rx byte", 9'h03C, {1'b0, RX_DATA});
      chk("rx ack wire", 9'h078, sh);
      send_en <= 1'b0;
      wr(`ICT_OFS_CON, 8'h40);
      wait_bit(3, 1'b1);
      rchk("rx nack code", `ICT_OFS_STAT, 8'h58);
      chk("rx nack wire", 9'h1FF, sh);
      wr(`ICT_OFS_CON, 8'h70);
      wait_bit(3, 1'b1);
      chk("stop then start", 9'h068, {1'b0, d});
      rchk("restart code", `ICT_OFS_STAT, 8'h08);
      wr(`ICT_OFS_CON, 8'h50);
      wait_bit(4, 1'b0);
      chk("halt cleared", 9'h040, {1'b0, d});
      rchk("idle code", `ICT_OFS_STAT, 8'hF8);
      chk("pins after stop", 9'h00F, pins);
      wr(`ICT_OFS_CON, 8'h00);
      $display("bus test done");
      summarize();
   end
   initial begin
      #(90000 * 50);
      num_errors++;
      summarize();
   end
endmodule
